// File: adc_output_ctrl.v
// converter output word timing, power-down hold and mode decode
// Contract
// [RULE1] sample appears 1.5 sample clocks after taken; code drives it on the next rise, 0.5 sample clocks after the fall capture
// [RULE2] output word updates on sample clock rise
// [RULE3] power-down holds last output word driven
// [RULE4] undefined codes 7.5 clocks after power-down release
// [RULE5] capturer ignores output through recovery window
// [RULE6] two power pins select sleep/warmup/calib/active
// [RULE7] two reference pins select divider ratio
// [RULE8] four parallel data lines, external sample clock
// [RULE9] any non-active mode counts as power-down
`timescale 1ns/100ps
`include "adc_out_consts.vh"
module adc_output_ctrl (
  // clock and reset
  input wire sys_clk,
  input wire arst_n,
  // sample clock from baseband, synchronous level
  input wire sample_clock_in,
  // raw converter result from the analog core
  input wire [3:0] conv_data,
  // power and reference selection pins
  input wire power_ctl_a,
  input wire power_ctl_b,
  input wire ref_sel_a,
  input wire ref_sel_b,
  // data output lines
  output reg sample_bit0,
  output reg sample_bit1,
  output reg sample_bit2,
  output reg sample_bit3,
  // status and decoded controls
  output reg out_valid_reg,
  output reg pll_on_reg,
  output reg adc_on_reg,
  output reg [1:0] mode_reg,
  output reg [1:0] ratio_sel_reg,
  output reg fifo_overflow_reg
);
  localparam ST_RUN = 3'b001;
  localparam ST_DOWN = 3'b010;
  localparam ST_RECOVER = 3'b100;

  reg clk_prev_reg;
  reg [2:0] state_reg;
  reg [3:0] half_cnt_reg;
  wire rise;
  wire fall;
  wire active;
  wire [1:0] pmode;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [3:0] fifo_out_data;
  reg [3:0] take_reg;
  reg take_valid_reg;
  wire pop;

  // mode decode from pins
  function is_active;
    input [1:0] m;
    begin
      is_active = (m == `PWR_ACTIVE); // [RULE9]
    end
  endfunction

  // pll runs in every mode but sleep
  function is_pll_on;
    input [1:0] m;
    begin
      is_pll_on = (m != `PWR_SLEEP); // [RULE6]
    end
  endfunction

  assign pmode = {power_ctl_a, power_ctl_b}; // [RULE6]
  assign active = is_active(pmode);
  assign rise = sample_clock_in & ~clk_prev_reg; // [RULE2]
  assign fall = ~sample_clock_in & clk_prev_reg;
  // drain on rising edges while running only
  assign pop = rise && (state_reg == ST_RUN) && fifo_out_valid;

  // sample clock edge detection
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      clk_prev_reg <= 1'b0;
    else
      clk_prev_reg <= sample_clock_in;
  end

  // capture on falling edge (half period into pipeline)
  // only while running: codes taken during recovery are undefined
  // and would pile up in the fifo, stretching the output latency
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      take_reg <= 4'h0;
      take_valid_reg <= 1'b0;
    end else begin
      take_valid_reg <= fall && active && (state_reg == ST_RUN); // [RULE1]
      if (fall)
        take_reg <= conv_data;
    end
  end

  sample_fifo #(
    .WIDTH(`SAMPLE_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .in_valid(take_valid_reg),
    .in_ready(fifo_in_ready),
    .in_data(take_reg),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  // power state and recovery counter
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_DOWN;
      half_cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (!active)
            state_reg <= ST_DOWN; // [RULE9]
        end
        // recovery window opens on the first fall after release
        // so that the count starts from a known clock phase
        ST_DOWN: begin
          if (active && fall) begin
            state_reg <= ST_RECOVER; // [RULE4]
            half_cnt_reg <= 4'h0;
          end
        end
        // both sample clock edges count: 15 halves make 7.5 periods
        // dropping out of active mode restarts the whole wait
        ST_RECOVER: begin
          if (!active)
            state_reg <= ST_DOWN;
          else if (rise || fall) begin
            half_cnt_reg <= half_cnt_reg + 4'h1;
            if (half_cnt_reg == `RECOVER_HALF - 4'h1)
              state_reg <= ST_RUN; // [RULE4]
          end
        end
        default: state_reg <= ST_DOWN;
      endcase
    end
  end

  // output word: new sample on rise, held otherwise
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_bit0 <= 1'b0;
      sample_bit1 <= 1'b0;
      sample_bit2 <= 1'b0;
      sample_bit3 <= 1'b0;
    end else begin
      if (pop) begin
        {sample_bit3, sample_bit2, sample_bit1, sample_bit0} <=
          fifo_out_data; // [RULE1] [RULE8]
      end
    end
  end

  // word valid flag; word itself is held through power-down
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      out_valid_reg <= 1'b0;
    else
      out_valid_reg <= (state_reg == ST_RUN) && active; // [RULE3] [RULE5]
  end

  // decoded mode copy
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      mode_reg <= `PWR_SLEEP;
    else
      mode_reg <= pmode; // [RULE6]
  end

  // pll enable
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      pll_on_reg <= 1'b0;
    else
      pll_on_reg <= is_pll_on(pmode); // [RULE6]
  end

  // converter enable
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      adc_on_reg <= 1'b0;
    else
      adc_on_reg <= active; // [RULE6]
  end

  // divider ratio code
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      ratio_sel_reg <= `REF_16M;
    else
      ratio_sel_reg <= {ref_sel_a, ref_sel_b}; // [RULE7]
  end

  // sticky overflow, cleared by reset only
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      fifo_overflow_reg <= 1'b0;
    else
      fifo_overflow_reg <= fifo_overflow_reg |
        (take_valid_reg & ~fifo_in_ready);
  end
endmodule // adc_output_ctrl

// File: adc_out_consts.vh
// constants for the converter output and mode control block
`ifndef ADC_OUT_CONSTS_VH
`define ADC_OUT_CONSTS_VH
`define SAMPLE_W 4
`define FIFO_DEPTH 8
// power mode codes {power_ctl_a, power_ctl_b}
`define PWR_SLEEP 2'h0
`define PWR_ACTIVE 2'h1
`define PWR_WARMUP 2'h2
`define PWR_CALIB 2'h3
// reference select codes {ref_sel_a, ref_sel_b}
`define REF_16M 2'h0
`define REF_19M2 2'h1
`define REF_14M4 2'h2
`define REF_26M 2'h3
// recovery after power-down: 7.5 sample periods, counted in half periods
`define RECOVER_HALF 4'hF
`endif

// File: sample_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module sample_fifo #(
  parameter WIDTH = 4,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire sys_clk,
  input wire arst_n,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_reg;
  reg [AW:0] rd_ptr_reg;
  wire empty;
  wire full;
  // pointer compare for full and empty
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
    (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];
  // storage write
  always @(posedge sys_clk) begin
    if (in_valid && !full)
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
  end
  // pointers
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (out_ready && !empty)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule // sample_fifo

// File: adc_output_ctrl_asserts.sv
// port assertions for the converter output control block
`timescale 1ns/100ps
module adc_output_ctrl_asserts (
  // clock and reset
  input wire sys_clk,
  input wire arst_n,
  // pins in
  input wire sample_clock_in,
  input wire [3:0] conv_data,
  input wire power_ctl_a, power_ctl_b, ref_sel_a, ref_sel_b,
  // outputs
  input wire sample_bit0, sample_bit1, sample_bit2, sample_bit3,
  input wire out_valid_reg, pll_on_reg, adc_on_reg, fifo_overflow_reg,
  input wire [1:0] mode_reg,
  input wire [1:0] ratio_sel_reg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire [3:0] w = {sample_bit3, sample_bit2, sample_bit1, sample_bit0};
  // two cycles out of active mode
  sequence s_off; !adc_on_reg ##1 !adc_on_reg; endsequence
  sequence s_wake; $rose(out_valid_reg); endsequence
  AST_MODE: assert property ($past(arst_n, 2) |->
    mode_reg == $past({power_ctl_a, power_ctl_b})) else $error("mode");
  AST_PLL: assert property (pll_on_reg == (mode_reg != 2'h0))
    else $error("pll");
  AST_ADC: assert property (adc_on_reg == (mode_reg == 2'h1))
    else $error("adc on");
  AST_RATIO: assert property ($past(arst_n, 2) |->
    ratio_sel_reg == $past({ref_sel_a, ref_sel_b})) else $error("ratio");
  AST_HOLD: assert property (s_off |-> $stable(w))
    else $error("word moved in power-down");
  AST_VALID: assert property (!adc_on_reg |=> !out_valid_reg)
    else $error("valid while down");
  AST_EDGE: assert property ($changed(w) |-> $past(sample_clock_in))
    else $error("word moved off rise");
  AST_RECOV: assert property (s_wake |-> $past(adc_on_reg, 56))
    else $error("recovery short");
  AST_OVF: assert property (fifo_overflow_reg |=> fifo_overflow_reg)
    else $error("overflow flag lost");
endmodule // adc_output_ctrl_asserts

// File: sample_source.sv
// baseband side: sample clock and stepping converter code
`timescale 1ns/100ps
module sample_source (
  // clock
  input wire sys_clk,
  // to block
  output reg sample_clock_in,
  output reg [3:0] conv_data
);
  reg [1:0] cnt_reg = 2'h0;
  initial sample_clock_in = 1'b0;
  initial conv_data = 4'h0;
  // half period 4 cycles, code steps once a period
  always @(posedge sys_clk) begin
    cnt_reg <= cnt_reg + 2'h1;
    if (cnt_reg == 2'h3) begin
      sample_clock_in <= ~sample_clock_in;
      if (!sample_clock_in) conv_data <= conv_data + 4'h1;
    end
  end
endmodule // sample_source

// File: test_adc_output_ctrl.sv
// testbench for the converter output control block
`timescale 1ns/100ps
`include "adc_out_consts.vh"
module test_adc_output_ctrl;
  reg sys_clk = 1'b0, arst_n = 1'b0;
  reg power_ctl_a = 1'b0, power_ctl_b = 1'b0;
  reg ref_sel_a = 1'b0, ref_sel_b = 1'b0;
  wire sample_clock_in, b0, b1, b2, b3, vld, pll, adc, ovf;
  wire [3:0] conv_data;
  wire [1:0] mode, ratio;
  wire [3:0] w = {b3, b2, b1, b0};
  integer err_total = 0, tests_run = 0, cyc = 0, i;
  reg [3:0] prev;
  reg [3:0] exp_w;
  always #2 sys_clk = ~sys_clk;
  sample_source u_src (.sys_clk(sys_clk),
    .sample_clock_in(sample_clock_in), .conv_data(conv_data));
  adc_output_ctrl u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .sample_clock_in(sample_clock_in), .conv_data(conv_data),
    .power_ctl_a(power_ctl_a), .power_ctl_b(power_ctl_b),
    .ref_sel_a(ref_sel_a), .ref_sel_b(ref_sel_b),
    .sample_bit0(b0), .sample_bit1(b1), .sample_bit2(b2),
    .sample_bit3(b3), .out_valid_reg(vld), .pll_on_reg(pll),
    .adc_on_reg(adc), .mode_reg(mode), .ratio_sel_reg(ratio),
    .fifo_overflow_reg(ovf));
  task check(input [7:0] seen, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  task set_mode(input [1:0] m);
    begin
      @(posedge sys_clk);
      {power_ctl_a, power_ctl_b} <= m;
      repeat (3) @(posedge sys_clk);
    end
  endtask
  // every power and reference code
  task t_decode;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        @(posedge sys_clk);
        {ref_sel_a, ref_sel_b} <= i[1:0];
        set_mode(i[1:0]);
        check(ratio, i[1:0]);
        check({mode, pll, adc}, {i[1:0], i != 0, i == 1});
      end
    end
  endtask
  // wake, recovery length, then words in order
  task t_stream;
    begin
      set_mode(`PWR_ACTIVE);
      for (i = 0; i < 300 && vld !== 1'b1; i = i + 1) @(posedge sys_clk);
      check(i > 55, 1'b1);
      @(w) prev = w;
      repeat (3) begin
        @(w);
        exp_w = prev + 4'h1;
        check(w, exp_w);
        exp_w = conv_data - 4'h1;
        check(w, exp_w);
        check(sample_clock_in, 1'b1);
        prev = w;
      end
      check(ovf, 1'b0);
    end
  endtask
  // non-active mode holds the word
  task t_hold;
    begin
      set_mode(`PWR_WARMUP);
      prev = w;
      repeat (40) @(posedge sys_clk);
      check(w, prev);
      check(vld, 1'b0);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      summarize;
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_decode;
    t_stream;
    t_hold;
    t_stream;
    summarize;
  end
endmodule // test_adc_output_ctrl
bind adc_output_ctrl adc_output_ctrl_asserts u_chk (.*);
